// *** core/count_polarity_pkg.sv ***
package count_polarity_pkg;

  // Delay times in ns
  localparam int TRIG_BASE_NS     = 1500;
  localparam int TRIG_ZERO_NS     = 6000;
  localparam int TRIG_SIGN_NS     = 9000;
  localparam int CLK_PERIOD_NS    = 10;
  localparam int TRIG_BASE_CYC    = (TRIG_BASE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_ZERO_CYC    = (TRIG_ZERO_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int TRIG_SIGN_CYC    = (TRIG_SIGN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
  localparam int DELAY_W          = 10;

  // Overload threshold in kHz and rate window
  localparam int OVL_THRESH_KHZ   = 310;
  localparam int OVL_MIN_KHZ      = 305;
  localparam int OVL_MAX_KHZ      = 320;
  localparam int RATE_WINDOW_NS   = 100000;
  localparam int RATE_WINDOW_CYC  = RATE_WINDOW_NS / CLK_PERIOD_NS;
  localparam int RATE_W           = 14;
  localparam int CNT_W            = 8;

  // APB register byte addresses
  localparam logic [7:0] ADDR_CTRL   = 8'h00;
  localparam logic [7:0] ADDR_STATUS = 8'h04;
  localparam logic [7:0] ADDR_THRESH = 8'h08;

  // Control register fields
  localparam int CTRL_SAMPLE_BIT = 0;
  localparam int CTRL_BLANK_BIT  = 1;
  localparam int CTRL_RESET_BIT  = 2;
  localparam logic [31:0] CTRL_RESET_VAL = 32'h0000_0000;

  // Status register fields
  localparam int ST_INSIGN_BIT  = 0;
  localparam int ST_CNTSIGN_BIT = 1;
  localparam int ST_UP_BIT      = 2;
  localparam int ST_OVL_BIT     = 3;
  localparam int ST_ZERO_BIT    = 4;

  typedef struct packed {
    logic up;
    logic down;
    logic plus_ind;
    logic minus_ind;
  } dir_out_t;

  typedef struct packed {
    logic pos;
    logic neg;
  } chan_ev_t;

endpackage : count_polarity_pkg

// *** core/count_polarity_control.sv ***
// Notes on behaviour
// - Positive pulse sets input sign positive, negative pulse sets it negative.
// - While all decades are zero, count sign copies input sign.
// - Signs agree: assert up, hold down inactive.
// - Opposite pulse with nonzero count changes input sign only.
// - Signs disagree: assert down, hold up inactive.
// - Down counting lasts until sample ends or count reaches zero.
// - Zero during down count: count sign follows input, polarity swaps, up resumes.
// - Every channel pulse goes to the overload detector as one stream.
// - Each pulse fires a one-shot; decade clocked at its end, 1.5 us.
// - On zero detect the trigger delay stretches to 6 us.
// - On input sign change the trigger delay stretches to 9 us.
// - Zero detect is gated off outside the sample period.
// - With zero gated off, count sign holds until next measurement.
// - Plus indicator when count sign positive, minus when negative.
// - Both polarity outputs blank for frequency, AC or resistance function.
// - Pulse rate above about 310 kHz raises overload to all its consumers.
// - Reset clears the overload latch; detector pulse sets it.
// - Overload threshold adjustable between 305 and 320 kHz (30 to 32 pulses per window).
// - Detector retriggers latch while rate is over, defeating reset.
// - External contact or internal reset clears the overload latch.
module count_polarity_control
  import count_polarity_pkg::*;
#(
  parameter int TRIG_SIGN_CYCLES = TRIG_SIGN_CYC
) (
  // Clock and reset
  input  wire logic        core_clk,
  input  wire logic        srst,
  // Converter channels, counter zero line, sample, reset, clear and function inputs
  input  wire logic        pos_pulse_in,
  input  wire logic        neg_pulse_in,
  input  wire logic        zero_detect_in,
  input  wire logic        sample_period_in,
  input  wire logic        reset_pulse_in,
  input  wire logic        ext_clear_n_in,
  input  wire logic        frequency_function_in,
  input  wire logic        ac_function_in,
  input  wire logic        ohms_function_in,
  // Counter and indicator outputs
  output dir_out_t         dir_out,
  output logic             count_trigger,
  output logic             overload_rate_out,
  output logic             overload_out,
  // APB slave
  input  wire logic        psel,
  input  wire logic        penable,
  input  wire logic        pwrite,
  input  wire logic [7:0]  paddr,
  input  wire logic [31:0] pwdata,
  output logic [31:0]      prdata,
  output logic             pready,
  output logic             pslverr
);

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers
  logic [1:0] pos_s_r, neg_s_r, zero_s_r, samp_s_r, rst_s_r, clr_s_r;
  logic [1:0] frequency_function_s_r, ac_s_r, ohms_s_r;
  logic       pos_d_r, neg_d_r;

  always_ff @(posedge core_clk) begin
    pos_s_r  <= {pos_s_r[0], pos_pulse_in};
    neg_s_r  <= {neg_s_r[0], neg_pulse_in};
    zero_s_r <= {zero_s_r[0], zero_detect_in};
    samp_s_r <= {samp_s_r[0], sample_period_in};
    rst_s_r  <= {rst_s_r[0], reset_pulse_in};
    clr_s_r  <= {clr_s_r[0], ext_clear_n_in};
    frequency_function_s_r <= {frequency_function_s_r[0], frequency_function_in};
    ac_s_r   <= {ac_s_r[0], ac_function_in};
    ohms_s_r <= {ohms_s_r[0], ohms_function_in};
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pos_d_r <= 1'b0;
      neg_d_r <= 1'b0;
    end else begin
      pos_d_r <= pos_s_r[1];
      neg_d_r <= neg_s_r[1];
    end
  end

  chan_ev_t raw_ev;
  assign raw_ev.pos = pos_s_r[1] & ~pos_d_r;
  assign raw_ev.neg = neg_s_r[1] & ~neg_d_r;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic             sample_sw_r, blank_sw_r, soft_rst_r;
  logic [RATE_W-1:0] thresh_r;

  ////////////////////////////////////////////////////////////////////////////
  // Event serialiser: one pending negative event when both arrive
  logic     pend_neg_r;
  chan_ev_t ev;

  always_comb begin
    ev.pos = raw_ev.pos;
    ev.neg = pend_neg_r | (raw_ev.neg & ~raw_ev.pos);
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      pend_neg_r <= 1'b0;
    end else begin
      pend_neg_r <= raw_ev.pos & raw_ev.neg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Sign flip-flops
  logic input_sign_ff, count_sign_ff;   // 1 = negative
  logic zero_gated, sample_act;
  logic in_sign_nxt;

  assign sample_act = samp_s_r[1] | sample_sw_r;
  assign zero_gated = zero_s_r[1] & sample_act;

  always_comb begin
    in_sign_nxt = input_sign_ff;
    if (ev.pos) begin
      in_sign_nxt = 1'b0;
    end else if (ev.neg) begin
      in_sign_nxt = 1'b1;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      input_sign_ff <= 1'b0;
    end else begin
      input_sign_ff <= in_sign_nxt;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_sign_ff <= 1'b0;
    end else if (zero_gated) begin
      count_sign_ff <= in_sign_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Direction and polarity outputs
  logic agree, blank;
  assign agree = (input_sign_ff == count_sign_ff);
  assign blank = frequency_function_s_r[1] | ac_s_r[1] | ohms_s_r[1] | blank_sw_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      dir_out <= '0;
    end else begin
      dir_out.up        <= (input_sign_ff == count_sign_ff);
      dir_out.down      <= (input_sign_ff != count_sign_ff);
      dir_out.plus_ind  <= ~count_sign_ff & ~blank;
      dir_out.minus_ind <= count_sign_ff & ~blank;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overload rate output and trigger one-shot
  always_ff @(posedge core_clk) begin
    if (srst) begin
      overload_rate_out <= 1'b0;
    end else begin
      overload_rate_out <= ev.pos | ev.neg;
    end
  end

  logic [DELAY_W-1:0] shot_cnt_r;
  logic [DELAY_W-1:0] shot_age_r;
  logic               sign_chg;
  assign sign_chg = (in_sign_nxt != input_sign_ff);

  function automatic logic [DELAY_W-1:0] max_d(input logic [DELAY_W-1:0] a,
                                               input logic [DELAY_W-1:0] b);
    max_d = (a > b) ? a : b;
  endfunction : max_d

  // Cycles still owed to reach the zero stretch, counted from the event
  function automatic logic [DELAY_W-1:0] zero_left(input logic [DELAY_W-1:0] age);
    zero_left = (age < DELAY_W'(TRIG_ZERO_CYC)) ? DELAY_W'(TRIG_ZERO_CYC) - age : '0;
  endfunction : zero_left

  // Age of the running one-shot, so a held zero cannot stretch it forever
  always_ff @(posedge core_clk) begin
    if (srst) begin
      shot_age_r <= '0;
    end else if (ev.pos | ev.neg) begin
      shot_age_r <= '0;
    end else if (shot_cnt_r != '0) begin
      shot_age_r <= shot_age_r + DELAY_W'(1);
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      shot_cnt_r <= '0;
    end else if (ev.pos | ev.neg) begin
      if (sign_chg) begin
        shot_cnt_r <= DELAY_W'(TRIG_SIGN_CYCLES);
      end else if (zero_gated) begin
        shot_cnt_r <= DELAY_W'(TRIG_ZERO_CYC);
      end else begin
        shot_cnt_r <= DELAY_W'(TRIG_BASE_CYC);
      end
    end else if (shot_cnt_r != '0) begin
      if (zero_gated) begin
        shot_cnt_r <= max_d(shot_cnt_r, zero_left(shot_age_r)) - DELAY_W'(1);
      end else begin
        shot_cnt_r <= shot_cnt_r - DELAY_W'(1);
      end
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_trigger <= 1'b0;
    end else begin
      count_trigger <= (shot_cnt_r == DELAY_W'(1)) & ~(ev.pos | ev.neg) & sample_act;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Overload rate detector and latch
  logic [RATE_W-1:0] win_cnt_r;
  logic [RATE_W-1:0] rate_cnt_r;
  logic              over_prev_r;
  logic              ovl_pulse_r;
  logic              ovl_latch_r;
  logic              over_rate;

  // Last window's verdict keeps the detector firing across window edges
  assign over_rate = (rate_cnt_r > thresh_r) | over_prev_r;

  always_ff @(posedge core_clk) begin
    if (srst) begin
      win_cnt_r   <= '0;
      rate_cnt_r  <= '0;
      over_prev_r <= 1'b0;
    end else if (win_cnt_r == RATE_W'(RATE_WINDOW_CYC - 1)) begin
      win_cnt_r   <= '0;
      rate_cnt_r  <= RATE_W'(ev.pos | ev.neg);
      over_prev_r <= (rate_cnt_r > thresh_r);
    end else begin
      win_cnt_r  <= win_cnt_r + RATE_W'(1);
      if (ev.pos | ev.neg) begin
        rate_cnt_r <= rate_cnt_r + RATE_W'(1);
      end
    end
  end

  // Detector retriggers each cycle while the rate stays over
  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovl_pulse_r <= 1'b0;
    end else begin
      ovl_pulse_r <= over_rate;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      ovl_latch_r <= 1'b0;
    end else if (ovl_pulse_r) begin
      ovl_latch_r <= 1'b1;
    end else if (rst_s_r[1] | ~clr_s_r[1] | soft_rst_r) begin
      ovl_latch_r <= 1'b0;
    end
  end

  assign overload_out = ovl_latch_r;

  ////////////////////////////////////////////////////////////////////////////
  // APB slave
  logic wr_en, rd_sel;
  logic [RATE_W-1:0] wthresh;
  assign wr_en   = psel & penable & pwrite;
  assign rd_sel  = psel & ~pwrite;
  assign pready  = 1'b1;
  assign wthresh = pwdata[RATE_W-1:0];

  always_ff @(posedge core_clk) begin
    if (srst) begin
      sample_sw_r <= CTRL_RESET_VAL[CTRL_SAMPLE_BIT];
      blank_sw_r  <= CTRL_RESET_VAL[CTRL_BLANK_BIT];
      soft_rst_r  <= 1'b0;
    end else begin
      soft_rst_r <= 1'b0;
      if (wr_en && paddr == ADDR_CTRL) begin
        sample_sw_r <= pwdata[CTRL_SAMPLE_BIT];
        blank_sw_r  <= pwdata[CTRL_BLANK_BIT];
        soft_rst_r  <= pwdata[CTRL_RESET_BIT];
      end
    end
  end

  // Threshold in pulses per window, clamped to the allowed band
  localparam logic [RATE_W-1:0] TH_DEF = RATE_W'(OVL_THRESH_KHZ * RATE_WINDOW_NS / 1000000);
  localparam logic [RATE_W-1:0] TH_MIN = RATE_W'(OVL_MIN_KHZ * RATE_WINDOW_NS / 1000000);
  localparam logic [RATE_W-1:0] TH_MAX = RATE_W'(OVL_MAX_KHZ * RATE_WINDOW_NS / 1000000);

  always_ff @(posedge core_clk) begin
    if (srst) begin
      thresh_r <= TH_DEF;
    end else if (wr_en && paddr == ADDR_THRESH) begin
      thresh_r <= (wthresh < TH_MIN) ? TH_MIN :
                  (wthresh > TH_MAX) ? TH_MAX : wthresh;
    end
  end

  always_ff @(posedge core_clk) begin
    if (srst) begin
      prdata  <= '0;
      pslverr <= 1'b0;
    end else begin
      pslverr <= 1'b0;
      if (rd_sel && !penable) begin
        prdata <= '0;
        case (paddr)
          ADDR_CTRL: begin
            prdata[CTRL_SAMPLE_BIT] <= sample_sw_r;
            prdata[CTRL_BLANK_BIT]  <= blank_sw_r;
          end
          ADDR_STATUS: begin
            prdata[ST_INSIGN_BIT]  <= input_sign_ff;
            prdata[ST_CNTSIGN_BIT] <= count_sign_ff;
            prdata[ST_UP_BIT]      <= agree;
            prdata[ST_OVL_BIT]     <= ovl_latch_r;
            prdata[ST_ZERO_BIT]    <= zero_gated;
          end
          ADDR_THRESH: prdata[RATE_W-1:0] <= thresh_r;
          default: prdata <= '0;
        endcase
      end
      if (psel && !penable && !(paddr inside {ADDR_CTRL, ADDR_STATUS, ADDR_THRESH})) begin
        pslverr <= 1'b1;
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  sequence s_pos_ev;
    ev.pos;
  endsequence

  chk_pos_sets_sign: assert property (@(posedge core_clk) disable iff (srst)
    s_pos_ev |=> !input_sign_ff) else $error("pos event did not set sign");
  chk_neg_sets_sign: assert property (@(posedge core_clk) disable iff (srst)
    ev.neg && !ev.pos |=> input_sign_ff) else $error("neg event did not set sign");
  chk_zero_copies_sign: assert property (@(posedge core_clk) disable iff (srst)
    zero_gated |=> count_sign_ff == input_sign_ff) else $error("zero copy failed");
  chk_up_on_agree: assert property (@(posedge core_clk) disable iff (srst)
    agree |=> dir_out.up && !dir_out.down) else $error("up line wrong");
  chk_down_on_differ: assert property (@(posedge core_clk) disable iff (srst)
    !agree |=> dir_out.down && !dir_out.up) else $error("down line wrong");
  chk_count_sign_hold: assert property (@(posedge core_clk) disable iff (srst)
    !zero_gated |=> $stable(count_sign_ff)) else $error("count sign moved");
  chk_rate_forward: assert property (@(posedge core_clk) disable iff (srst)
    (ev.pos || ev.neg) |=> overload_rate_out) else $error("rate pulse missing");
  chk_both_serial: assert property (@(posedge core_clk) disable iff (srst)
    raw_ev.pos && raw_ev.neg |=> ev.neg) else $error("second event lost");
  chk_blank_ind: assert property (@(posedge core_clk) disable iff (srst)
    blank |=> !dir_out.plus_ind && !dir_out.minus_ind) else $error("blank failed");
  chk_plus_ind: assert property (@(posedge core_clk) disable iff (srst)
    !blank && !count_sign_ff |=> dir_out.plus_ind && !dir_out.minus_ind)
    else $error("plus indicator wrong");
  chk_ovl_set: assert property (@(posedge core_clk) disable iff (srst)
    ovl_pulse_r |=> overload_out) else $error("overload not latched");
  chk_trig_gated: assert property (@(posedge core_clk) disable iff (srst)
    !sample_act |=> !count_trigger) else $error("trigger outside sample period");
  chk_trig_single: assert property (@(posedge core_clk) disable iff (srst)
    count_trigger |=> !count_trigger) else $error("trigger longer than one cycle");

endmodule : count_polarity_control

// *** sim/vfc_counter_model.sv ***
module vfc_counter_model
  import count_polarity_pkg::*;
(
  // Clock and reset
  input  wire logic     core_clk,
  input  wire logic     srst,
  // Bench requests
  input  wire logic     send_pos,
  input  wire logic     send_neg,
  // Block outputs
  input  wire dir_out_t dir_out,
  input  wire logic     count_trigger,
  // Channel and zero lines
  output logic          pos_pulse,
  output logic          neg_pulse,
  output logic          zero_det
);
  logic [2:0]  pos_w_r;
  logic [2:0]  neg_w_r;
  logic [15:0] count_r;

  // Converter pulses, four cycles high
  always_ff @(posedge core_clk) begin
    if (srst) begin
      pos_w_r <= 3'h0;
      neg_w_r <= 3'h0;
    end else begin
      pos_w_r <= send_pos ? 3'h4 : pos_w_r - {2'h0, pos_w_r != 3'h0};
      neg_w_r <= send_neg ? 3'h4 : neg_w_r - {2'h0, neg_w_r != 3'h0};
    end
  end

  // Reversible decades
  always_ff @(posedge core_clk) begin
    if (srst) begin
      count_r <= 16'h0000;
    end else if (count_trigger && dir_out.up) begin
      count_r <= count_r + 16'h0001;
    end else if (count_trigger && dir_out.down && count_r != 16'h0000) begin
      count_r <= count_r - 16'h0001;
    end
  end

  assign pos_pulse = (pos_w_r != 3'h0);
  assign neg_pulse = (neg_w_r != 3'h0);
  assign zero_det  = (count_r == 16'h0000);
endmodule : vfc_counter_model

// *** sim/count_polarity_control_tb.sv ***
module count_polarity_control_tb
  import count_polarity_pkg::*;
;
  timeunit 1ns;
  timeprecision 1ns;
  localparam int SIGN_CYC = 300;
  logic        core_clk, srst, send_pos, send_neg, pos_pulse, neg_pulse, zero_det;
  logic        sample_on, reset_pulse, ext_clear_n, frequency_function_fn, ac_fn, ohms_fn;
  dir_out_t    dir_out;
  logic        count_trigger, rate_pulse, overload, last_err;
  logic        psel, penable, pwrite, pready, pslverr;
  logic [7:0]  paddr;
  logic [31:0] pwdata, prdata;
  int          num_errors, tests_run;

  count_polarity_control #(.TRIG_SIGN_CYCLES(SIGN_CYC)) u_count_polarity_control (
    .core_clk(core_clk), .srst(srst), .pos_pulse_in(pos_pulse), .neg_pulse_in(neg_pulse),
    .zero_detect_in(zero_det), .sample_period_in(sample_on), .reset_pulse_in(reset_pulse),
    .ext_clear_n_in(ext_clear_n), .frequency_function_in(frequency_function_fn), .ac_function_in(ac_fn),
    .ohms_function_in(ohms_fn), .dir_out(dir_out), .count_trigger(count_trigger),
    .overload_rate_out(rate_pulse), .overload_out(overload), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr));

  vfc_counter_model u_vfc_counter_model (
    .core_clk(core_clk), .srst(srst), .send_pos(send_pos), .send_neg(send_neg),
    .dir_out(dir_out), .count_trigger(count_trigger), .pos_pulse(pos_pulse),
    .neg_pulse(neg_pulse), .zero_det(zero_det));

  always #5 core_clk = ~core_clk;

  ////////////////////////////////////////////////////////////
  task automatic final_report();
    $display("Checks %0d, mismatches %0d", tests_run, num_errors);
    if (num_errors == 0 && tests_run > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask : final_report

  task automatic check(input logic [31:0] got, input logic [31:0] exp);
    tests_run++;
    if (got !== exp) begin
      num_errors++;
      $display("FAIL t=%0t got=%h exp=%h", $time, got, exp);
    end
  endtask : check

  task automatic wait_hi(ref logic s, input int lim, output int n);
    n = 0;
    while (s !== 1'b1 && n < lim) begin
      @(posedge core_clk);
      n++;
    end
    if (s !== 1'b1) begin
      num_errors++;
      final_report();
    end
  endtask : wait_hi

  // Setup then access until pready, release one edge later
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] wd,
                     output logic [31:0] rd);
    int n;
    psel    <= 1'b1;
    pwrite  <= wr;
    paddr   <= a;
    pwdata  <= wd;
    @(posedge core_clk);
    penable <= 1'b1;
    @(posedge core_clk);
    wait_hi(pready, 50, n);
    rd       = prdata;
    last_err = pslverr;
    psel    <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask : apb

  task automatic rd(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] d;
    apb(1'b0, a, 32'h0, d);
    check(d & m, exp);
  endtask : rd

  // One channel pulse; trigger delay must sit near exp
  task automatic fire(input logic neg, input int exp);
    int n;
    send_pos <= !neg;
    send_neg <= neg;
    @(posedge core_clk);
    send_pos <= 1'b0;
    send_neg <= 1'b0;
    wait_hi(rate_pulse, 20, n);
    wait_hi(count_trigger, 1000, n);
    check(32'(n > exp - 8 && n < exp + 8), 32'h1);
    repeat (12) @(posedge core_clk);
  endtask : fire

  task automatic burst(input int n, input int rst_at);
    for (int i = 0; i < n; i++) begin
      send_pos    <= 1'b1;
      reset_pulse <= (i == rst_at);
      @(posedge core_clk);
      send_pos    <= 1'b0;
      reset_pulse <= 1'b0;
      repeat (7) @(posedge core_clk);
    end
  endtask : burst

  ////////////////////////////////////////////////////////////
  task automatic t_regs();
    logic [31:0] d;
    check(32'({dir_out, overload}), 32'h14);
    rd(ADDR_CTRL, 32'hFFFFFFFF, CTRL_RESET_VAL);
    rd(ADDR_THRESH, 32'hFF, 32'h1F);
    apb(1'b1, ADDR_THRESH, 32'h3F, d);
    rd(ADDR_THRESH, 32'hFF, 32'h20);
    apb(1'b1, ADDR_THRESH, 32'h00, d);
    rd(ADDR_THRESH, 32'hFF, 32'h1E);
    apb(1'b1, ADDR_THRESH, 32'h1F, d);
    check(32'(last_err), 32'h0);
    rd(8'h0C, 32'hFFFFFFFF, 32'h0);
    check(32'(last_err), 32'h1);
    $display("t_regs done");
  endtask : t_regs

  task automatic t_sign();
    sample_on <= 1'b1;
    repeat (8) @(posedge core_clk);
    fire(1'b0, TRIG_ZERO_CYC);
    check(32'(dir_out), 32'hA);
    fire(1'b0, TRIG_BASE_CYC);
    fire(1'b1, SIGN_CYC);
    check(32'(dir_out), 32'h6);
    fire(1'b1, TRIG_BASE_CYC);
    check(32'(dir_out), 32'h9);
    rd(ADDR_STATUS, 32'h3, 32'h3);
    $display("t_sign done");
  endtask : t_sign

  task automatic t_blank();
    logic [31:0] d;
    for (int i = 0; i < 3; i++) begin
      {frequency_function_fn, ac_fn, ohms_fn} <= 3'(1 << i);
      repeat (4) @(posedge core_clk);
      check(32'(dir_out.plus_ind | dir_out.minus_ind), 32'h0);
    end
    {frequency_function_fn, ac_fn, ohms_fn} <= 3'h0;
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_BLANK_BIT, d);
    repeat (2) @(posedge core_clk);
    check(32'(dir_out.plus_ind | dir_out.minus_ind), 32'h0);
    apb(1'b1, ADDR_CTRL, 32'h0, d);
    repeat (4) @(posedge core_clk);
    check(32'(dir_out.minus_ind), 32'h1);
    $display("t_blank done");
  endtask : t_blank

  task automatic t_gate();
    int n;
    sample_on <= 1'b0;
    repeat (8) @(posedge core_clk);
    send_pos <= 1'b1;
    @(posedge core_clk);
    send_pos <= 1'b0;
    n = 0;
    repeat (700) begin
      @(posedge core_clk);
      if (count_trigger === 1'b1) n++;
    end
    check(32'(n), 32'h0);
    check(32'(dir_out), 32'h5);
    sample_on <= 1'b1;
    repeat (12) @(posedge core_clk);
    check(32'(dir_out), 32'hA);
    $display("t_gate done");
  endtask : t_gate

  task automatic t_both();
    int n;
    send_pos <= 1'b1;
    send_neg <= 1'b1;
    @(posedge core_clk);
    send_pos <= 1'b0;
    send_neg <= 1'b0;
    n = 0;
    repeat (30) begin
      @(posedge core_clk);
      if (rate_pulse === 1'b1) n++;
    end
    check(32'(n), 32'h2);
    repeat (1000) @(posedge core_clk);
    rd(ADDR_STATUS, 32'h1, 32'h1);
    $display("t_both done");
  endtask : t_both

  task automatic t_ovl();
    logic [31:0] d;
    burst(1300, -1);
    check(32'(overload), 32'h1);
    rd(ADDR_STATUS, 32'h8, 32'h8);
    burst(1300, 10);
    check(32'(overload), 32'h1);
    repeat (21000) @(posedge core_clk);
    reset_pulse <= 1'b1;
    @(posedge core_clk);
    reset_pulse <= 1'b0;
    repeat (4) @(posedge core_clk);
    check(32'(overload), 32'h0);
    burst(80, -1);
    check(32'(overload), 32'h1);
    repeat (21000) @(posedge core_clk);
    ext_clear_n <= 1'b0;
    repeat (3) @(posedge core_clk);
    ext_clear_n <= 1'b1;
    repeat (4) @(posedge core_clk);
    check(32'(overload), 32'h0);
    burst(80, -1);
    check(32'(overload), 32'h1);
    repeat (21000) @(posedge core_clk);
    apb(1'b1, ADDR_CTRL, 32'h1 << CTRL_RESET_BIT, d);
    repeat (2) @(posedge core_clk);
    check(32'(overload), 32'h0);
    $display("t_ovl done");
  endtask : t_ovl

  ////////////////////////////////////////////////////////////
  initial begin
    core_clk = 1'b0;
    srst = 1'b1;
    {send_pos, send_neg, sample_on, reset_pulse, frequency_function_fn, ac_fn, ohms_fn} = 7'h00;
    {psel, penable, pwrite, last_err} = 4'h0;
    ext_clear_n = 1'b1;
    paddr = 8'h00;
    pwdata = 32'h0;
    num_errors = 0;
    tests_run = 0;
    repeat (6) @(posedge core_clk);
    srst <= 1'b0;
    repeat (3) @(posedge core_clk);
    t_regs();
    t_sign();
    t_blank();
    t_gate();
    t_both();
    t_ovl();
    final_report();
  end
endmodule : count_polarity_control_tb
